// file: rtl/rpp_top.sv
// two-channel relative move pulse train generator with register port
// assumes one 40 MHz clock, synchronous pins, strobes of one cycle
`timescale 1ns/1ps
`default_nettype none

module rpp_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// register port
	input wire rpp_pkg::rpp_bus_req_s bus_req,
	output logic [15:0] rd_data,
	// mark sensors
	input wire logic ch1_mark_input,
	input wire logic ch2_mark_input,
	// drive pins
	output logic ch1_pulse_pin,
	output logic ch1_dir_pin,
	output logic ch2_pulse_pin,
	output logic ch2_dir_pin
);
	logic rst_s1_q;
	logic rst_n;
	logic [1:0] mark_in;
	logic [1:0] pulse_q;
	logic [1:0] dirp_q;
	logic [31:0] len_reg_q [2];
	logic [31:0] tf_reg_q [2];
	logic [31:0] mstop_reg_q [2];
	logic [31:0] mask_reg_q [2];
	logic [15:0] sf_reg_q [2];
	logic [15:0] ramp_reg_q [2];
	logic [15:0] adec_reg_q [2];
	logic [15:0] ctrl_q [2];
	logic [15:0] dly_reg_q [2];
	logic [15:0] ext_q [16];
	logic [31:0] pos_w [2];
	logic [15:0] stat_w [2];
	logic [15:0] rd_d;
	logic [4:0] off;

	assign mark_in = {ch2_mark_input, ch1_mark_input};
	assign off = bus_req.addr[4:0];
	assign ch1_pulse_pin = pulse_q[0];
	assign ch1_dir_pin = dirp_q[0];
	assign ch2_pulse_pin = pulse_q[1];
	assign ch2_dir_pin = dirp_q[1];

	function automatic logic ch_hit(input logic [7:0] a, input int c);
		return a[7:rpp_pkg::CH_SEL_LSB] == 3'(c);
	endfunction

	function automatic logic [31:0] clamp_f(input logic [31:0] v);
		if (v < rpp_pkg::FREQ_MIN) begin
			return rpp_pkg::FREQ_MIN;
		end else if (v > rpp_pkg::FREQ_MAX) begin
			return rpp_pkg::FREQ_MAX;
		end
		return v;
	endfunction

	function automatic logic [31:0] ramp_cyc(input logic [15:0] v);
		logic [15:0] t;
		t = v;
		if (v < rpp_pkg::RAMP_MIN) begin
			t = rpp_pkg::RAMP_MIN;
		end else if (v > rpp_pkg::RAMP_MAX) begin
			t = rpp_pkg::RAMP_MAX;
		end
		return 32'({16'h0000, t} * rpp_pkg::CYC_PER_MS);
	endfunction

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rst_s1_q <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n <= rst_s1_q;
		end
	end

	// main channel parameter registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++) begin
				len_reg_q[i] <= 32'h0;
				tf_reg_q[i] <= 32'h0;
				mstop_reg_q[i] <= 32'h0;
				mask_reg_q[i] <= 32'h0;
				sf_reg_q[i] <= 16'h0;
				ramp_reg_q[i] <= rpp_pkg::RAMP_RST;
				adec_reg_q[i] <= rpp_pkg::RAMP_RST;
				ctrl_q[i] <= 16'h0;
				dly_reg_q[i] <= 16'h0;
			end
		end else if (bus_req.wr) begin
			for (int i = 0; i < 2; i++) begin
				if (ch_hit(bus_req.addr, i)) begin
					case (off)
						rpp_pkg::O_LEN_LO: len_reg_q[i][15:0] <= bus_req.wdata;
						rpp_pkg::O_LEN_HI: len_reg_q[i][31:16] <= bus_req.wdata;
						rpp_pkg::O_TF_LO: tf_reg_q[i][15:0] <= bus_req.wdata;
						rpp_pkg::O_TF_HI: tf_reg_q[i][31:16] <= bus_req.wdata;
						rpp_pkg::O_SF: sf_reg_q[i] <= bus_req.wdata;
						rpp_pkg::O_RAMP: ramp_reg_q[i] <= bus_req.wdata;
						rpp_pkg::O_ADEC: adec_reg_q[i] <= bus_req.wdata;
						rpp_pkg::O_MSTOP_LO: mstop_reg_q[i][15:0] <= bus_req.wdata;
						rpp_pkg::O_MSTOP_HI: mstop_reg_q[i][31:16] <= bus_req.wdata;
						rpp_pkg::O_MASK_LO: mask_reg_q[i][15:0] <= bus_req.wdata;
						rpp_pkg::O_MASK_HI: mask_reg_q[i][31:16] <= bus_req.wdata;
						rpp_pkg::O_CTRL: ctrl_q[i] <= bus_req.wdata;
						rpp_pkg::O_DLY: dly_reg_q[i] <= bus_req.wdata;
						default: ;
					endcase
				end
			end
		end
	end

	// third and fourth channel words, kept for software
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 16; i++) begin
				ext_q[i] <= 16'h0;
			end
			ext_q[rpp_pkg::X_CH3_RAMP] <= rpp_pkg::RAMP_RST;
			ext_q[rpp_pkg::X_CH4_RAMP] <= rpp_pkg::RAMP_RST;
		end else if (bus_req.wr && bus_req.addr[7:4] == rpp_pkg::EXT_HI) begin
			if (bus_req.addr[3:0] == rpp_pkg::X_CH3_PHASE || bus_req.addr[3:0] == rpp_pkg::X_CH4_PHASE) begin
				ext_q[bus_req.addr[3:0]] <= {14'h0000, bus_req.wdata[1:0]};
			end else begin
				ext_q[bus_req.addr[3:0]] <= bus_req.wdata;
			end
		end
	end

	genvar c;
	for (c = 0; c < 2; c++) begin : g_ch
		rpp_pkg::rpp_state_e st_q;
		rpp_pkg::rpp_phase_e mode_q;
		logic run;
		logic run_q;
		logic mark_q;
		logic mark_rise;
		logic tog;
		logic cnt_pulse;
		logic [31:0] left_q;
		logic [31:0] up_q;
		logic [31:0] f_q;
		logic [31:0] tf_q;
		logic [31:0] sf_q;
		logic [31:0] diff_q;
		logic [31:0] rup_q;
		logic [31:0] rdn_q;
		logic [31:0] racc_q;
		logic [31:0] acc_q;
		logic [31:0] pos_q;
		logic [31:0] msk_q;
		logic [31:0] mstop_q;
		logic [31:0] dly_q;
		logic [31:0] acc_n;
		logic [31:0] racc_n;
		logic [31:0] ftgt;
		logic [31:0] fst;
		logic [1:0] ph_q;
		logic dir_q;
		logic rev_q;
		logic dec_q;
		logic done_q;
		logic paused_q;
		logic auto_q;
		logic stopi_q;
		logic maske_q;
		logic marked_q;

		assign run = ctrl_q[c][rpp_pkg::B_RUN];
		assign ftgt = clamp_f(tf_reg_q[c]);
		assign fst = clamp_f({16'h0000, sf_reg_q[c]});
		assign acc_n = acc_q + {f_q[30:0], 1'b0};
		// no step in a pause or cut cycle, else position counts a pulse never sent
		assign tog = (st_q == rpp_pkg::ST_RUN) && !ctrl_q[c][rpp_pkg::B_PAUSE] && (run || !stopi_q)
			&& (acc_n >= rpp_pkg::CLK_CYC);
		// second toggle of a pair closes one pulse
		assign cnt_pulse = tog && ph_q[0];
		assign racc_n = racc_q + diff_q;
		assign mark_rise = mark_in[c] && !mark_q && maske_q && !marked_q && msk_q == 32'h0;
		assign pos_w[c] = pos_q;
		assign stat_w[c] = {12'h000, dir_q, st_q != rpp_pkg::ST_IDLE, paused_q, done_q};

		// move engine
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				st_q <= rpp_pkg::ST_IDLE;
				mode_q <= rpp_pkg::PH_PULSE;
				run_q <= 1'b0;
				mark_q <= 1'b0;
				{left_q, up_q, f_q, tf_q, sf_q, diff_q} <= '0;
				{rup_q, rdn_q, racc_q, acc_q, msk_q, mstop_q, dly_q} <= '0;
				ph_q <= 2'b00;
				{dir_q, rev_q, dec_q, done_q, paused_q, auto_q, stopi_q, maske_q, marked_q} <= '0;
			end else begin
				run_q <= run;
				mark_q <= mark_in[c];
				case (st_q)
					rpp_pkg::ST_IDLE: begin
						dir_q <= 1'b0;
						// new move only from idle, one per channel
						if (run && !run_q) begin
							left_q <= len_reg_q[c][31] ? ~len_reg_q[c] + 32'h1 : len_reg_q[c];
							rev_q <= len_reg_q[c][31];
							dir_q <= len_reg_q[c][31] && !ctrl_q[c][rpp_pkg::B_INV];
							tf_q <= ftgt;
							sf_q <= (fst > ftgt) ? ftgt : fst;
							f_q <= (fst > ftgt) ? ftgt : fst;
							diff_q <= (ftgt > fst) ? ftgt - fst : 32'h0;
							rup_q <= ramp_cyc(ramp_reg_q[c]);
							rdn_q <= ctrl_q[c][rpp_pkg::B_ADEC] ? ramp_cyc(adec_reg_q[c]) : ramp_cyc(ramp_reg_q[c]);
							mode_q <= rpp_pkg::rpp_phase_e'(ctrl_q[c][rpp_pkg::B_PH_LSB +: 2]);
							auto_q <= ctrl_q[c][rpp_pkg::B_AUTO];
							stopi_q <= ctrl_q[c][rpp_pkg::B_STOPI];
							maske_q <= ctrl_q[c][rpp_pkg::B_MASK];
							msk_q <= ctrl_q[c][rpp_pkg::B_MASK] ? mask_reg_q[c] : 32'h0;
							mstop_q <= mstop_reg_q[c];
							dly_q <= 32'({16'h0000, dly_reg_q[c]} * rpp_pkg::CYC_PER_US);
							{acc_q, racc_q, up_q} <= '0;
							ph_q <= 2'b00;
							{dec_q, marked_q, done_q, paused_q} <= '0;
							st_q <= rpp_pkg::ST_DELAY;
						end
					end
					rpp_pkg::ST_DELAY: begin
						if (!run || left_q == 32'h0) begin
							done_q <= 1'b1;
							st_q <= rpp_pkg::ST_HOLD;
						end else if (dly_q == 32'h0) begin
							st_q <= rpp_pkg::ST_RUN;
						end else begin
							dly_q <= dly_q - 32'h1;
						end
					end
					rpp_pkg::ST_RUN: begin
						if (!run && stopi_q) begin
							done_q <= 1'b1;
							st_q <= rpp_pkg::ST_HOLD;
						end else if (ctrl_q[c][rpp_pkg::B_PAUSE]) begin
							paused_q <= 1'b1;
							st_q <= rpp_pkg::ST_PAUSE;
						end else begin
							if (!run) begin
								dec_q <= 1'b1;
							end
							acc_q <= tog ? acc_n - rpp_pkg::CLK_CYC : acc_n;
							if (tog) begin
								ph_q <= ph_q + 2'b01;
							end
							if (cnt_pulse) begin
								left_q <= left_q - 32'h1;
								if (msk_q != 32'h0) begin
									msk_q <= msk_q - 32'h1;
								end
								if (!dec_q && f_q < tf_q) begin
									up_q <= up_q + 32'h1;
								end
								if (left_q == 32'h1 || (!run && f_q <= sf_q)) begin
									done_q <= 1'b1;
									st_q <= rpp_pkg::ST_HOLD;
								end
							end else if (left_q <= up_q) begin
								dec_q <= 1'b1;
							end
							if (mark_rise) begin
								marked_q <= 1'b1;
								left_q <= (mstop_q == 32'h0) ? 32'h1 : mstop_q;
							end
							// frequency ramp, at most one step per cycle
							if (!dec_q && f_q < tf_q) begin
								if (racc_n >= rup_q) begin
									f_q <= f_q + 32'h1;
									racc_q <= racc_n - rup_q;
								end else begin
									racc_q <= racc_n;
								end
							end else if (dec_q && f_q > sf_q) begin
								if (racc_n >= rdn_q) begin
									f_q <= f_q - 32'h1;
									racc_q <= racc_n - rdn_q;
								end else begin
									racc_q <= racc_n;
								end
							end
						end
					end
					rpp_pkg::ST_PAUSE: begin
						if (!run) begin
							paused_q <= 1'b0;
							done_q <= 1'b1;
							st_q <= rpp_pkg::ST_HOLD;
						end else if (!ctrl_q[c][rpp_pkg::B_PAUSE]) begin
							paused_q <= 1'b0;
							st_q <= rpp_pkg::ST_RUN;
						end
					end
					rpp_pkg::ST_HOLD: begin
						// direction kept until the enable drops
						if (!run) begin
							dir_q <= 1'b0;
							st_q <= rpp_pkg::ST_IDLE;
						end
					end
					default: st_q <= rpp_pkg::ST_IDLE;
				endcase
			end
		end

		// current position
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				pos_q <= 32'h0;
			end else if (cnt_pulse) begin
				pos_q <= rev_q ? pos_q - 32'h1 : pos_q + 32'h1;
			end else if (bus_req.wr && ch_hit(bus_req.addr, c) && st_q == rpp_pkg::ST_IDLE) begin
				if (off == rpp_pkg::O_POS_LO) begin
					pos_q[15:0] <= bus_req.wdata;
				end else if (off == rpp_pkg::O_POS_HI) begin
					pos_q[31:16] <= bus_req.wdata;
				end
			end
		end

		// pin drivers
		always_ff @(posedge sys_clk or negedge rst_n) begin
			if (!rst_n) begin
				pulse_q[c] <= 1'b0;
				dirp_q[c] <= 1'b0;
			end else begin
				case (mode_q)
					rpp_pkg::PH_PULSE: begin
						pulse_q[c] <= ph_q[0];
						dirp_q[c] <= dir_q;
					end
					rpp_pkg::PH_AB: begin
						pulse_q[c] <= ph_q[1] ^ ph_q[0];
						dirp_q[c] <= ph_q[1];
					end
					rpp_pkg::PH_BA: begin
						pulse_q[c] <= ph_q[1];
						dirp_q[c] <= ph_q[1] ^ ph_q[0];
					end
					default: begin
						pulse_q[c] <= 1'b0;
						dirp_q[c] <= ph_q[0];
					end
				endcase
				if (auto_q && (st_q == rpp_pkg::ST_HOLD || st_q == rpp_pkg::ST_IDLE)) begin
					pulse_q[c] <= 1'b0;
				end
			end
		end
	end

	// read decode
	always_comb begin
		rd_d = 16'h0000;
		if (bus_req.addr[7:rpp_pkg::CH_SEL_LSB] < 3'h2) begin
			case (off)
				rpp_pkg::O_LEN_LO: rd_d = len_reg_q[bus_req.addr[rpp_pkg::CH_SEL_LSB]][15:0];
				rpp_pkg::O_LEN_HI: rd_d = len_reg_q[bus_req.addr[rpp_pkg::CH_SEL_LSB]][31:16];
				rpp_pkg::O_TF_LO: rd_d = tf_reg_q[bus_req.addr[rpp_pkg::CH_SEL_LSB]][15:0];
				rpp_pkg::O_TF_HI: rd_d = tf_reg_q[bus_req.addr[rpp_pkg::CH_SEL_LSB]][31:16];
				rpp_pkg::O_POS_LO: rd_d = pos_w[bus_req.addr[rpp_pkg::CH_SEL_LSB]][15:0];
				rpp_pkg::O_POS_HI: rd_d = pos_w[bus_req.addr[rpp_pkg::CH_SEL_LSB]][31:16];
				rpp_pkg::O_SF: rd_d = sf_reg_q[bus_req.addr[rpp_pkg::CH_SEL_LSB]];
				rpp_pkg::O_RAMP: rd_d = ramp_reg_q[bus_req.addr[rpp_pkg::CH_SEL_LSB]];
				rpp_pkg::O_ADEC: rd_d = adec_reg_q[bus_req.addr[rpp_pkg::CH_SEL_LSB]];
				rpp_pkg::O_MSTOP_LO: rd_d = mstop_reg_q[bus_req.addr[rpp_pkg::CH_SEL_LSB]][15:0];
				rpp_pkg::O_MSTOP_HI: rd_d = mstop_reg_q[bus_req.addr[rpp_pkg::CH_SEL_LSB]][31:16];
				rpp_pkg::O_MASK_LO: rd_d = mask_reg_q[bus_req.addr[rpp_pkg::CH_SEL_LSB]][15:0];
				rpp_pkg::O_MASK_HI: rd_d = mask_reg_q[bus_req.addr[rpp_pkg::CH_SEL_LSB]][31:16];
				rpp_pkg::O_CTRL: rd_d = ctrl_q[bus_req.addr[rpp_pkg::CH_SEL_LSB]];
				rpp_pkg::O_STAT: rd_d = stat_w[bus_req.addr[rpp_pkg::CH_SEL_LSB]];
				rpp_pkg::O_DLY: rd_d = dly_reg_q[bus_req.addr[rpp_pkg::CH_SEL_LSB]];
				default: rd_d = 16'h0000;
			endcase
		end else if (bus_req.addr[7:4] == rpp_pkg::EXT_HI) begin
			rd_d = ext_q[bus_req.addr[3:0]];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 16'h0000;
		end else if (bus_req.rd) begin
			rd_data <= rd_d;
		end else begin
			rd_data <= 16'h0000;
		end
	end
endmodule // rpp_top

`default_nettype wire

// file: rtl/rpp_pkg.sv
// constants, register map and carrier types for the relative pulse positioner
// assumes a 40 MHz system clock and a 16-bit register port with 8-bit word addresses
package rpp_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam logic [31:0] CLK_CYC = 32'(CLK_HZ);
	localparam logic [31:0] CYC_PER_MS = 32'(CLK_HZ / 1000);
	localparam logic [31:0] CYC_PER_US = 32'(CLK_HZ / 1_000_000);

	localparam logic [31:0] FREQ_MIN = 32'h0000_0006;
	localparam logic [31:0] FREQ_MAX = 32'h0001_86A0;
	localparam logic [15:0] RAMP_MIN = 16'h0014;
	localparam logic [15:0] RAMP_MAX = 16'h7FFF;
	localparam logic [15:0] RAMP_RST = 16'h0064;

	// address layout: channel blocks at 0x00 and 0x20, extra channels at 0x40
	localparam int CH_SEL_LSB = 5;
	localparam logic [3:0] EXT_HI = 4'h4;

	localparam logic [4:0] O_LEN_LO = 5'h00;
	localparam logic [4:0] O_LEN_HI = 5'h01;
	localparam logic [4:0] O_TF_LO = 5'h02;
	localparam logic [4:0] O_TF_HI = 5'h03;
	localparam logic [4:0] O_POS_LO = 5'h04;
	localparam logic [4:0] O_POS_HI = 5'h05;
	localparam logic [4:0] O_SF = 5'h06;
	localparam logic [4:0] O_RAMP = 5'h07;
	localparam logic [4:0] O_ADEC = 5'h08;
	localparam logic [4:0] O_MSTOP_LO = 5'h09;
	localparam logic [4:0] O_MSTOP_HI = 5'h0A;
	localparam logic [4:0] O_MASK_LO = 5'h0B;
	localparam logic [4:0] O_MASK_HI = 5'h0C;
	localparam logic [4:0] O_CTRL = 5'h0D;
	localparam logic [4:0] O_STAT = 5'h0E;
	localparam logic [4:0] O_DLY = 5'h0F;

	// extra block word offsets (ch3 at 0x0, ch4 at 0x8)
	localparam logic [3:0] X_CH3_CNT_LO = 4'h0;
	localparam logic [3:0] X_CH3_CNT_HI = 4'h1;
	localparam logic [3:0] X_CH3_SF = 4'h2;
	localparam logic [3:0] X_CH3_RAMP = 4'h3;
	localparam logic [3:0] X_CH3_ADEC = 4'h4;
	localparam logic [3:0] X_CH3_DLY = 4'h5;
	localparam logic [3:0] X_CH3_PHASE = 4'h6;
	localparam logic [3:0] X_ALT_CNT_LO = 4'h7;
	localparam logic [3:0] X_CH4_CNT_LO = 4'h8;
	localparam logic [3:0] X_CH4_CNT_HI = 4'h9;
	localparam logic [3:0] X_CH4_SF = 4'hA;
	localparam logic [3:0] X_CH4_RAMP = 4'hB;
	localparam logic [3:0] X_CH4_ADEC = 4'hC;
	localparam logic [3:0] X_CH4_DLY = 4'hD;
	localparam logic [3:0] X_CH4_PHASE = 4'hE;
	localparam logic [3:0] X_ALT_CNT_HI = 4'hF;

	// control word bits
	localparam int B_RUN = 0;
	localparam int B_PAUSE = 1;
	localparam int B_MASK = 3;
	localparam int B_INV = 4;
	localparam int B_AUTO = 5;
	localparam int B_ADEC = 6;
	localparam int B_STOPI = 7;
	localparam int B_PH_LSB = 8;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} rpp_bus_req_s;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DELAY = 3'b001,
		ST_RUN = 3'b010,
		ST_PAUSE = 3'b011,
		ST_HOLD = 3'b100
	} rpp_state_e;

	typedef enum logic [1:0] {
		PH_PULSE = 2'b00,
		PH_AB = 2'b01,
		PH_BA = 2'b10,
		PH_ON_DIR = 2'b11
	} rpp_phase_e;
endpackage

// file: verif/rpp_drive_model.sv
// drive-side model: tallies steps per direction like a pulse and direction drive
// assumes a step is taken on the falling edge of the step pin, sampled on sys_clk
`timescale 1ns/1ps
`default_nettype none
module rpp_drive_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// drive inputs
	input wire logic step_pin,
	input wire logic dir_pin,
	// step totals
	output logic [31:0] fwd_cnt,
	output logic [31:0] rev_cnt
);
	logic step_q;
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			step_q <= 1'b0;
			fwd_cnt <= 32'h0000_0000;
			rev_cnt <= 32'h0000_0000;
		end else begin
			step_q <= step_pin;
			if (step_q && !step_pin && dir_pin) begin
				rev_cnt <= rev_cnt + 32'h0000_0001;
			end else if (step_q && !step_pin) begin
				fwd_cnt <= fwd_cnt + 32'h0000_0001;
			end
		end
	end
endmodule // rpp_drive_model
`default_nettype wire

// file: verif/rpp_monitor.sv
// port checker for the relative pulse positioner
// assumes it is bound onto rpp_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module rpp_monitor (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// register port
	input wire rpp_pkg::rpp_bus_req_s bus_req,
	input wire logic [15:0] rd_data,
	// pins
	input wire logic ch1_mark_input,
	input wire logic ch2_mark_input,
	input wire logic ch1_pulse_pin,
	input wire logic ch1_dir_pin,
	input wire logic ch2_pulse_pin,
	input wire logic ch2_dir_pin
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	chk_rd_quiet: assert property (!$past(bus_req.rd) |-> rd_data == 16'h0000)
		else $error("read data outside its slot");
	chk_p1_high_min: assert property ($rose(ch1_pulse_pin) |=> ch1_pulse_pin [*8])
		else $error("ch1 pulse high too short");
	chk_p2_high_min: assert property ($rose(ch2_pulse_pin) |=> ch2_pulse_pin [*8])
		else $error("ch2 pulse high too short");
	chk_p1_low_min: assert property ($fell(ch1_pulse_pin) |=> !ch1_pulse_pin [*8])
		else $error("ch1 pulse low too short");
	chk_p2_low_min: assert property ($fell(ch2_pulse_pin) |=> !ch2_pulse_pin [*8])
		else $error("ch2 pulse low too short");
	chk_d1_step_steady: assert property ($fell(ch1_pulse_pin) |-> $stable(ch1_dir_pin))
		else $error("ch1 direction moved at a step");
	chk_d2_step_steady: assert property ($fell(ch2_pulse_pin) |-> $stable(ch2_dir_pin))
		else $error("ch2 direction moved at a step");
	chk_d2_set_first: assert property ($rose(ch2_dir_pin) |-> !ch2_pulse_pin)
		else $error("ch2 direction set during a pulse");
	cover property ($rose(ch1_pulse_pin));
	cover property ($rose(ch2_dir_pin));
	cover property ($fell(ch2_dir_pin));
endmodule // rpp_monitor
bind rpp_top rpp_monitor u_mon (.sys_clk(sys_clk), .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data),
	.ch1_mark_input(ch1_mark_input), .ch2_mark_input(ch2_mark_input), .ch1_pulse_pin(ch1_pulse_pin),
	.ch1_dir_pin(ch1_dir_pin), .ch2_pulse_pin(ch2_pulse_pin), .ch2_dir_pin(ch2_dir_pin));
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench for the relative pulse positioner
// assumes rpp_top with its checker bound, one drive model per channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; $display("[ERR] %0t got %h want %h", $time, a, b); end end
module testbench;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	rpp_pkg::rpp_bus_req_s bus_req = '0;
	logic [15:0] rd_data;
	logic p1, d1, p2, d2;
	logic m1 = 1'b0;
	logic m2 = 1'b0;
	logic [31:0] f1, r1, f2, r2;
	int err_count = 0;
	int n_tests = 0;
	int cyc = 0;
	always #12.5 sys_clk = ~sys_clk;
	rpp_top DUT (.sys_clk(sys_clk), .arst_n(arst_n), .bus_req(bus_req), .rd_data(rd_data),
		.ch1_mark_input(m1), .ch2_mark_input(m2), .ch1_pulse_pin(p1), .ch1_dir_pin(d1),
		.ch2_pulse_pin(p2), .ch2_dir_pin(d2));
	rpp_drive_model drv1 (.sys_clk(sys_clk), .arst_n(arst_n), .step_pin(p1), .dir_pin(d1), .fwd_cnt(f1), .rev_cnt(r1));
	rpp_drive_model drv2 (.sys_clk(sys_clk), .arst_n(arst_n), .step_pin(p2), .dir_pin(d2), .fwd_cnt(f2), .rev_cnt(r2));
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge sys_clk);
		bus_req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1 d = rd_data;
	endtask
	// length, 40 kHz target and start so no ramp stretches the run
	task automatic load(input logic [7:0] b, input logic [31:0] len);
		wr(b, len[15:0]);
		wr(b + 8'h01, len[31:16]);
		wr(b + 8'h02, 16'h9C40);
		wr(b + 8'h03, 16'h0000);
		wr(b + 8'h06, 16'h9C40);
		wr(b + 8'h0F, 16'h0000);
	endtask
	task automatic done(input logic [7:0] b);
		logic [15:0] s;
		s = 16'h0000;
		for (int i = 0; i < 200 && s[0] !== 1'b1; i++) begin
			repeat (100) @(posedge sys_clk);
			rd(b + 8'h0E, s);
		end
		// let the drive model take the last falling step
		repeat (4) @(posedge sys_clk);
		`CHK(s[0], 1'b1)
	endtask
	task automatic pos(input logic [7:0] b, input logic [31:0] e);
		logic [15:0] lo, hi;
		rd(b + 8'h04, lo);
		rd(b + 8'h05, hi);
		`CHK({hi, lo}, e)
	endtask
	task automatic t_reset();
		logic [15:0] v;
		rd(8'h07, v);
		`CHK(v, 16'h0064)
		rd(8'h28, v);
		`CHK(v, 16'h0064)
		rd(8'h4B, v);
		`CHK(v, 16'h0064)
		wr(8'h40, 16'hA5C3);
		rd(8'h40, v);
		`CHK(v, 16'hA5C3)
		rd(8'h50, v);
		`CHK(v, 16'h0000)
		wr(8'h46, 16'hFFFF);
		rd(8'h46, v);
		`CHK(v, 16'h0003)
	endtask
	task automatic t_both();
		load(8'h00, 32'h0000_0004);
		load(8'h20, 32'hFFFF_FFFD);
		wr(8'h0D, 16'h0001);
		wr(8'h2D, 16'h0001);
		done(8'h00);
		done(8'h20);
		`CHK(f1, 32'h0000_0004)
		`CHK(r2, 32'h0000_0003)
		`CHK(d1, 1'b0)
		`CHK(d2, 1'b1)
		pos(8'h00, 32'h0000_0004);
		pos(8'h20, 32'hFFFF_FFFD);
		wr(8'h0D, 16'h0000);
		wr(8'h2D, 16'h0000);
		repeat (3) @(posedge sys_clk);
		`CHK(d2, 1'b0)
	endtask
	task automatic t_invert();
		load(8'h20, 32'hFFFF_FFFE);
		wr(8'h2D, 16'h0011);
		done(8'h20);
		`CHK(d2, 1'b0)
		`CHK(f2, 32'h0000_0002)
		pos(8'h20, 32'hFFFF_FFFB);
		wr(8'h2D, 16'h0000);
	endtask
	task automatic t_pause();
		logic [15:0] v;
		logic [31:0] c;
		load(8'h00, 32'h0000_0006);
		wr(8'h0D, 16'h0021);
		for (int i = 0; i < 20000 && f1 < 32'd6; i++) @(posedge sys_clk);
		wr(8'h0D, 16'h0023);
		wr(8'h00, 16'h0064);
		rd(8'h0E, v);
		`CHK(v[1], 1'b1)
		c = f1;
		repeat (3000) @(posedge sys_clk);
		`CHK(f1, c)
		wr(8'h0D, 16'h0021);
		done(8'h00);
		`CHK(f1, 32'h0000_000A)
		`CHK(p1, 1'b0)
		pos(8'h00, 32'h0000_000A);
		wr(8'h0D, 16'h0000);
	endtask
	task automatic t_stop();
		logic [31:0] c;
		load(8'h00, 32'h0000_0064);
		wr(8'h0D, 16'h0081);
		for (int i = 0; i < 20000 && f1 < 32'd13; i++) @(posedge sys_clk);
		wr(8'h0D, 16'h0080);
		repeat (3) @(posedge sys_clk);
		c = f1;
		repeat (3000) @(posedge sys_clk);
		`CHK(f1, c)
		`CHK(d1, 1'b0)
		pos(8'h00, c);
	endtask
	// mark after the first step cuts the move to two further pulses
	task automatic t_mark();
		logic [31:0] c;
		c = f2;
		load(8'h20, 32'h0000_0064);
		wr(8'h29, 16'h0002);
		wr(8'h2A, 16'h0000);
		wr(8'h2D, 16'h0009);
		for (int i = 0; i < 5000 && f2 < c + 32'h1; i++) @(posedge sys_clk);
		m2 <= 1'b1;
		done(8'h20);
		`CHK(f2, c + 32'h3)
		pos(8'h20, 32'hFFFF_FFFE);
		m2 <= 1'b0;
		wr(8'h2D, 16'h0000);
	endtask
	// enable dropped without stop flag: the next pulse to complete ends the move
	task automatic t_decel();
		logic [31:0] c;
		c = f1;
		load(8'h00, 32'h0000_0064);
		wr(8'h0D, 16'h0001);
		for (int i = 0; i < 5000 && f1 < c + 32'h2; i++) @(posedge sys_clk);
		wr(8'h0D, 16'h0000);
		done(8'h00);
		`CHK(f1, c + 32'h3)
		pos(8'h00, c + 32'h3);
	endtask
	// quadrature modes: first step shows the leading phase
	task automatic t_phase();
		load(8'h00, 32'h0000_0002);
		wr(8'h0D, 16'h0101);
		for (int i = 0; i < 5000 && p1 !== 1'b1 && d1 !== 1'b1; i++) @(posedge sys_clk);
		`CHK(p1, 1'b1)
		`CHK(d1, 1'b0)
		done(8'h00);
		wr(8'h0D, 16'h0000);
		load(8'h00, 32'h0000_0001);
		wr(8'h0D, 16'h0221);
		for (int i = 0; i < 5000 && p1 !== 1'b1 && d1 !== 1'b1; i++) @(posedge sys_clk);
		`CHK(p1, 1'b0)
		`CHK(d1, 1'b1)
		done(8'h00);
		`CHK(p1, 1'b0)
		`CHK(d1, 1'b1)
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		t_reset();
		t_both();
		t_invert();
		t_mark();
		t_pause();
		t_stop();
		t_decel();
		t_phase();
		conclude();
	end
	// hang guard
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			conclude();
		end
	end
endmodule // testbench
`default_nettype wire
